/* hdl/ofcd_top.sv */
/*
 * Output frequency and output current detection for a motor inverter.
 * Assumes inputs synchronous to CLK_SYS_IN, frequencies in 0.01 Hz,
 * currents and levels in 0.1 % of rated current, times in ms.
 */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////
module ofcd_top
    import ofcd_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
)
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic [FREQ_W-1:0] SET_FREQ_IN,
    input wire logic [FREQ_W-1:0] OUT_FREQ_RAW_IN,
    input wire logic [PCT_W-1:0] OUT_CURRENT_IN,
    input wire logic REVERSE_IN,
    input wire logic DC_BRAKE_IN,
    input wire logic RUNNING_IN,
    input wire logic TUNING_IN,
    input wire logic [1:0] USER_GROUP_SELECT_IN,
    input wire logic WR_EN_IN,
    input wire logic [2:0] WR_SEL_IN,
    input wire logic [FREQ_W-1:0] WR_DATA_IN,
    output logic WR_DONE_OUT,
    output logic WR_REJECT_OUT,
    output logic AT_SPEED_FLAG_OUT,
    output logic FREQ_THRESHOLD_FLAG_OUT,
    output logic OVERCURRENT_FLAG_OUT,
    output logic ZERO_CURRENT_FLAG_OUT
);
    // refuse a tick period that the millisecond counter cannot serve
    if (CYC_MS < 1)
    begin : g_bad_cyc_ms
        $error("CYC_MS must be at least one");
    end

    // setting selectors for the write port
    localparam logic [2:0] SEL_BAND = 3'h0;
    localparam logic [2:0] SEL_FWD = 3'h1;
    localparam logic [2:0] SEL_REV = 3'h2;
    localparam logic [2:0] SEL_OC_LEVEL = 3'h3;
    localparam logic [2:0] SEL_OC_DELAY = 3'h4;
    localparam logic [2:0] SEL_ZC_LEVEL = 3'h5;
    localparam logic [2:0] SEL_ZC_TIME = 3'h6;
    localparam logic [15:0] PCT_DIV = 16'h03E8;

    logic [PCT_W-1:0] speed_band_setting;
    logic [FREQ_W-1:0] forward_freq_threshold;
    logic [FREQ_W-1:0] reverse_freq_threshold;
    logic [PCT_W-1:0] overcurrent_level;
    logic [TIME_W-1:0] overcurrent_delay;
    logic [PCT_W-1:0] zero_current_level;
    logic [TIME_W-1:0] zero_current_time;
    logic [31:0] tick_cnt;
    logic tick;
    logic [FREQ_W-1:0] band;
    logic [FREQ_W-1:0] freq_diff;
    logic [FREQ_W-1:0] active_threshold;
    logic sense_on;
    logic oc_cond;
    logic zc_cond;
    logic [TIME_W-1:0] oc_qual;
    logic [TIME_W-1:0] zc_qual;
    logic oc_flag;
    logic zc_flag;

    // checks whether a written value sits inside its legal range
    function automatic logic in_range(input logic [2:0] sel, input logic [FREQ_W-1:0] val);
        unique case (sel)
            SEL_BAND: in_range = val <= FREQ_W'(BAND_FULL);
            SEL_FWD: in_range = val <= FREQ_MAX;
            SEL_REV: in_range = val <= FREQ_MAX || val == FREQ_SAME_AS_FWD;
            SEL_OC_LEVEL: in_range = val <= FREQ_W'(CUR_MAX);
            SEL_OC_DELAY: in_range = val <= FREQ_W'(OC_DELAY_MAX);
            SEL_ZC_LEVEL: in_range = val <= FREQ_W'(CUR_MAX);
            SEL_ZC_TIME: in_range = val <= FREQ_W'(ZC_TIME_MAX);
            default: in_range = 1'b0;
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////
    // setting writes, gated by the user group selection
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            speed_band_setting <= BAND_RST;
            forward_freq_threshold <= FWD_RST;
            reverse_freq_threshold <= REV_RST;
            overcurrent_level <= OC_LEVEL_RST;
            overcurrent_delay <= OC_DELAY_RST;
            zero_current_level <= ZC_LEVEL_RST;
            zero_current_time <= ZC_TIME_RST;
        end
        else if (WR_EN_IN && USER_GROUP_SELECT_IN == GROUP_OPEN
                 && in_range(WR_SEL_IN, WR_DATA_IN))
        begin
            unique case (WR_SEL_IN)
                SEL_BAND: speed_band_setting <= WR_DATA_IN[PCT_W-1:0];
                SEL_FWD: forward_freq_threshold <= WR_DATA_IN;
                SEL_REV: reverse_freq_threshold <= WR_DATA_IN;
                SEL_OC_LEVEL: overcurrent_level <= WR_DATA_IN[PCT_W-1:0];
                SEL_OC_DELAY: overcurrent_delay <= WR_DATA_IN[TIME_W-1:0];
                SEL_ZC_LEVEL: zero_current_level <= WR_DATA_IN[PCT_W-1:0];
                SEL_ZC_TIME: zero_current_time <= WR_DATA_IN[TIME_W-1:0];
                default: ;
            endcase
        end
    end

    // write answer: one-cycle done or reject pulse
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            WR_DONE_OUT <= 1'b0;
            WR_REJECT_OUT <= 1'b0;
        end
        else
        begin
            WR_DONE_OUT <= WR_EN_IN && USER_GROUP_SELECT_IN == GROUP_OPEN
                           && in_range(WR_SEL_IN, WR_DATA_IN);
            WR_REJECT_OUT <= WR_EN_IN && !(USER_GROUP_SELECT_IN == GROUP_OPEN
                             && in_range(WR_SEL_IN, WR_DATA_IN));
        end
    end

    //////////////////////////////////////////////////////////////////////
    // frequency comparisons on the pre-slip output frequency
    always_comb
    begin
        band = FREQ_W'((32'(SET_FREQ_IN) * 32'(speed_band_setting)) / 32'(PCT_DIV));
        if (OUT_FREQ_RAW_IN >= SET_FREQ_IN)
            freq_diff = OUT_FREQ_RAW_IN - SET_FREQ_IN;
        else
            freq_diff = SET_FREQ_IN - OUT_FREQ_RAW_IN;
        if (REVERSE_IN && reverse_freq_threshold != FREQ_SAME_AS_FWD)
            active_threshold = reverse_freq_threshold;
        else
            active_threshold = forward_freq_threshold;
    end

    // frequency flags, forced off while DC braking
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            AT_SPEED_FLAG_OUT <= 1'b0;
            FREQ_THRESHOLD_FLAG_OUT <= 1'b0;
        end
        else
        begin
            AT_SPEED_FLAG_OUT <= !DC_BRAKE_IN && freq_diff <= band;
            FREQ_THRESHOLD_FLAG_OUT <= !DC_BRAKE_IN
                                       && OUT_FREQ_RAW_IN >= active_threshold;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // millisecond tick
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else if (tick_cnt >= 32'(CYC_MS - 1))
        begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // current conditions, levels in tenths of a percent of rated current
    always_comb
    begin
        sense_on = RUNNING_IN || TUNING_IN;
        oc_cond = sense_on && OUT_CURRENT_IN > overcurrent_level;
        zc_cond = sense_on && zero_current_level != PCT_ZERO
                  && OUT_CURRENT_IN < zero_current_level;
        oc_qual = TIME_W'(overcurrent_delay + RESP_MS);
        zc_qual = TIME_W'(zero_current_time + RESP_MS);
    end

    // qualifying timers with hold stretch
    ofcd_qual u_oc
    (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .tick_in(tick),
        .cond_in(oc_cond),
        .qual_ms_in(oc_qual),
        .flag_out(oc_flag)
    );

    ofcd_qual u_zc
    (
        .clk_in(CLK_SYS_IN),
        .rst_b_in(RST_B_IN),
        .tick_in(tick),
        .cond_in(zc_cond),
        .qual_ms_in(zc_qual),
        .flag_out(zc_flag)
    );

    // current flags registered at the top
    always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            OVERCURRENT_FLAG_OUT <= 1'b0;
            ZERO_CURRENT_FLAG_OUT <= 1'b0;
        end
        else
        begin
            OVERCURRENT_FLAG_OUT <= oc_flag;
            ZERO_CURRENT_FLAG_OUT <= zc_flag;
        end
    end
endmodule

/* shared/ofcd_pkg.sv */
/*
 * Shared constants for the output frequency and current detection block.
 * Assumes frequencies in 0.01 Hz units, currents and current levels in 0.1 %
 * of rated inverter current, and times in milliseconds.
 */
package ofcd_pkg;
    // clock rate and derived millisecond tick
    localparam int CLK_HZ = 40000000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_MS = 1;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S * TICK_MS;
    // widths
    localparam int FREQ_W = 16;
    localparam int PCT_W = 11;
    localparam int TIME_W = 14;
    localparam int CNT_W = 16;
    // settings encodings
    localparam logic [FREQ_W-1:0] FREQ_SAME_AS_FWD = 16'h270F;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 16'h9C40;
    localparam logic [PCT_W-1:0] BAND_FULL = 11'h3E8;
    localparam logic [PCT_W-1:0] CUR_MAX = 11'h7D0;
    localparam logic [TIME_W-1:0] OC_DELAY_MAX = 14'h2710;
    localparam logic [TIME_W-1:0] ZC_TIME_MAX = 14'h03E8;
    localparam logic [PCT_W-1:0] PCT_ZERO = 11'h000;
    // reset values of the settings
    localparam logic [PCT_W-1:0] BAND_RST = 11'h064;
    localparam logic [FREQ_W-1:0] FWD_RST = 16'h0258;
    localparam logic [FREQ_W-1:0] REV_RST = 16'h270F;
    localparam logic [PCT_W-1:0] OC_LEVEL_RST = 11'h5DC;
    localparam logic [TIME_W-1:0] OC_DELAY_RST = 14'h0000;
    localparam logic [PCT_W-1:0] ZC_LEVEL_RST = 11'h032;
    localparam logic [TIME_W-1:0] ZC_TIME_RST = 14'h01F4;
    // hold and response figures in ms
    localparam logic [TIME_W-1:0] HOLD_MS = 14'h0064;
    localparam logic [TIME_W-1:0] RESP_MS = 14'h0064;
    // user group selection value that allows writes
    localparam logic [1:0] GROUP_OPEN = 2'h0;
endpackage

/* hdl/ofcd_qual.sv */
/*
 * Qualify-and-stretch timer for one current condition.
 * Assumes a one-cycle millisecond tick from the parent.
 */
`timescale 1ns/1ps
module ofcd_qual
    import ofcd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tick_in,
    input wire logic cond_in,
    input wire logic [TIME_W-1:0] qual_ms_in,
    output logic flag_out
);
    logic [TIME_W:0] qual_cnt;
    logic [TIME_W-1:0] hold_cnt;

    ////////////////////////////////////////////////////////////////////
    // qualifying timer: counts ms while the condition holds
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            qual_cnt <= '0;
        else if (!cond_in)
            qual_cnt <= '0;
        else if (tick_in && qual_cnt <= {1'b0, qual_ms_in})
            qual_cnt <= qual_cnt + 1'b1;
    end

    // flag rises after longer than the delay plus response time, then holds
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            flag_out <= 1'b0;
            hold_cnt <= '0;
        end
        else if (cond_in && qual_cnt > {1'b0, qual_ms_in})
        begin
            flag_out <= 1'b1;
            hold_cnt <= HOLD_MS;
        end
        else if (hold_cnt != '0)
        begin
            if (tick_in)
                hold_cnt <= hold_cnt - 1'b1;
        end
        else
            flag_out <= 1'b0;
    end
endmodule

/* bench/ofcd_props.sv */
/* checker for ofcd_top, bound to its ports.
   assumes thresholds change only through accepted writes. */
`timescale 1ns/1ps
module ofcd_props
    import ofcd_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
)
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_B_IN,
    input wire logic [FREQ_W-1:0] OUT_FREQ_RAW_IN,
    input wire logic REVERSE_IN,
    input wire logic DC_BRAKE_IN,
    input wire logic RUNNING_IN,
    input wire logic TUNING_IN,
    input wire logic [1:0] USER_GROUP_SELECT_IN,
    input wire logic WR_EN_IN,
    input wire logic [2:0] WR_SEL_IN,
    input wire logic [FREQ_W-1:0] WR_DATA_IN,
    input wire logic WR_DONE_OUT,
    input wire logic WR_REJECT_OUT,
    input wire logic AT_SPEED_FLAG_OUT,
    input wire logic FREQ_THRESHOLD_FLAG_OUT,
    input wire logic OVERCURRENT_FLAG_OUT,
    input wire logic ZERO_CURRENT_FLAG_OUT
);
localparam int HOLD_CYC = 99 * CYC_MS;
logic [FREQ_W-1:0] fwd, rev, thr;
logic [CNT_W-1:0] oc_on, zc_on;
logic wok;
logic sense;
////////////////////////////////////////////////////////////////////////////////
// shadow thresholds, loaded on the edge that takes an accepted write
assign wok = WR_EN_IN && USER_GROUP_SELECT_IN == GROUP_OPEN && WR_DATA_IN <= FREQ_MAX;
assign thr = (REVERSE_IN && rev != FREQ_SAME_AS_FWD) ? rev : fwd;
assign sense = RUNNING_IN || TUNING_IN;
always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
begin
    if (!RST_B_IN)
    begin
        fwd <= FWD_RST;
        rev <= REV_RST;
    end
    else if (wok)
    begin
        if (WR_SEL_IN == 3'h1)
            fwd <= WR_DATA_IN;
        if (WR_SEL_IN == 3'h2)
            rev <= WR_DATA_IN;
    end
end
// cycles each current flag has stood high
always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
begin
    if (!RST_B_IN)
    begin
        oc_on <= '0;
        zc_on <= '0;
    end
    else
    begin
        oc_on <= OVERCURRENT_FLAG_OUT ? oc_on + 1'h1 : '0;
        zc_on <= ZERO_CURRENT_FLAG_OUT ? zc_on + 1'h1 : '0;
    end
end
////////////////////////////////////////////////////////////////////////////////
// properties
default clocking cb @(posedge CLK_SYS_IN); endclocking
default disable iff (!RST_B_IN);
sequence s_closed_wr; WR_EN_IN && USER_GROUP_SELECT_IN != GROUP_OPEN; endsequence
sequence s_refused; WR_REJECT_OUT && !WR_DONE_OUT; endsequence
property p_closed; s_closed_wr |=> s_refused; endproperty
property p_quiet; !WR_EN_IN |=> !WR_DONE_OUT && !WR_REJECT_OUT; endproperty
property p_brake; DC_BRAKE_IN |=> !AT_SPEED_FLAG_OUT && !FREQ_THRESHOLD_FLAG_OUT; endproperty
property p_thresh;
    !DC_BRAKE_IN |=> FREQ_THRESHOLD_FLAG_OUT == ($past(OUT_FREQ_RAW_IN) >= $past(thr));
endproperty
property p_oc_cause; $rose(OVERCURRENT_FLAG_OUT) |-> $past(sense, 8); endproperty
property p_zc_cause; $rose(ZERO_CURRENT_FLAG_OUT) |-> $past(sense, 8); endproperty
property p_oc_hold; $fell(OVERCURRENT_FLAG_OUT) |-> $past(oc_on) >= HOLD_CYC; endproperty
property p_zc_hold; $fell(ZERO_CURRENT_FLAG_OUT) |-> $past(zc_on) >= HOLD_CYC; endproperty
a_closed: assert property (p_closed)
    else $error("write taken while group closed");
a_quiet: assert property (p_quiet)
    else $error("write answer without a write");
a_brake: assert property (p_brake)
    else $error("frequency flag set during braking");
a_thresh: assert property (p_thresh)
    else $error("frequency threshold flag wrong");
a_oc_cause: assert property (p_oc_cause)
    else $error("overcurrent flag while stopped");
a_zc_cause: assert property (p_zc_cause)
    else $error("zero current flag while stopped");
a_oc_hold: assert property (p_oc_hold)
    else $error("overcurrent flag hold too short");
a_zc_hold: assert property (p_zc_hold)
    else $error("zero current flag hold too short");
endmodule
bind ofcd_top ofcd_props #(.CYC_MS(CYC_MS)) ofcd_props_inst (.CLK_SYS_IN, .RST_B_IN,
    .OUT_FREQ_RAW_IN, .REVERSE_IN, .DC_BRAKE_IN, .RUNNING_IN, .TUNING_IN,
    .USER_GROUP_SELECT_IN, .WR_EN_IN, .WR_SEL_IN, .WR_DATA_IN, .WR_DONE_OUT, .WR_REJECT_OUT,
    .AT_SPEED_FLAG_OUT, .FREQ_THRESHOLD_FLAG_OUT, .OVERCURRENT_FLAG_OUT, .ZERO_CURRENT_FLAG_OUT);

/* bench/ofcd_master.sv */
/* remote master model: polls the four status flags every clock.
   assumes flags synchronous to clk_in. */
`timescale 1ns/1ps
module ofcd_master
    import ofcd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [3:0] flags_in,
    output logic [3:0] status_out,
    output logic [7:0] oc_events_out
);
// poll the flags and count overcurrent events
always_ff @(posedge clk_in or negedge rst_b_in)
begin
    if (!rst_b_in)
    begin
        status_out <= 4'h0;
        oc_events_out <= 8'h00;
    end
    else
    begin
        status_out <= flags_in;
        if (flags_in[2] && !status_out[2])
            oc_events_out <= oc_events_out + 8'h01;
    end
end
endmodule

/* bench/output_freq_current_detect_test.sv */
/* bench for ofcd_top: random frequency traffic, writes, current timing.
   assumes four clocks to a millisecond in the design. */
`timescale 1ns/1ps
module output_freq_current_detect_test;
import ofcd_pkg::*;
logic clk = 1'h0, rst_b = 1'h0, rev = 1'h0, brk = 1'h0, run = 1'h0, tun = 1'h0, en = 1'h0;
logic [1:0] grp = 2'h0;
logic [2:0] sel = 3'h0;
logic [15:0] setf = 16'h0, outf = 16'h0, wd = 16'h0, bnd = 16'h64, fth = 16'h258, rth = 16'h270F;
logic [15:0] o;
logic [10:0] cur = 11'h0;
logic su, fu, oc, zc, dn, rj;
logic [7:0] oc_seen;
int num_errors = 0, num_checks = 0, cyc = 0, n, m, i, j;
integer seed = 371;
localparam int TB_MS = 4;
always #12.5 clk = ~clk;
ofcd_top #(.CYC_MS(TB_MS)) ofcd_top_inst (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SET_FREQ_IN(setf),
    .OUT_FREQ_RAW_IN(outf), .OUT_CURRENT_IN(cur), .REVERSE_IN(rev), .DC_BRAKE_IN(brk),
    .RUNNING_IN(run), .TUNING_IN(tun), .USER_GROUP_SELECT_IN(grp), .WR_EN_IN(en),
    .WR_SEL_IN(sel), .WR_DATA_IN(wd), .WR_DONE_OUT(dn), .WR_REJECT_OUT(rj),
    .AT_SPEED_FLAG_OUT(su), .FREQ_THRESHOLD_FLAG_OUT(fu), .OVERCURRENT_FLAG_OUT(oc),
    .ZERO_CURRENT_FLAG_OUT(zc));
ofcd_master ofcd_master_inst (.clk_in(clk), .rst_b_in(rst_b), .flags_in({zc, oc, fu, su}),
    .status_out(), .oc_events_out(oc_seen));
////////////////////////////////////////////////////////////////////////////////
// expectations and checks
function automatic logic exp_su();
    logic [31:0] d;
    d = setf > outf ? setf - outf : outf - setf;
    return !brk && d <= setf * bnd / 32'h3E8;
endfunction
function automatic logic exp_fu();
    return !brk && outf >= ((rev && rth != FREQ_SAME_AS_FWD) ? rth : fth);
endfunction
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic wr(input logic [1:0] g, input logic [2:0] s, input logic [15:0] d, input logic ok);
    @(posedge clk);
    grp <= g;
    en <= 1'h1;
    sel <= s;
    wd <= d;
    @(posedge clk);
    en <= 1'h0;
    @(negedge clk);
    chk("wr_done", dn, ok);
    chk("wr_reject", rj, !ok);
endtask
task automatic step(input logic [15:0] s, input logic [15:0] f, input logic r, input logic b);
    @(posedge clk);
    setf <= s;
    outf <= f;
    rev <= r;
    brk <= b;
    @(posedge clk);
    @(negedge clk);
    chk("at_speed", su, exp_su());
    chk("freq_thr", fu, exp_fu());
endtask
// d is the programmed qualifying time in ms; response time is added on top
task automatic qual(input int w, input logic [10:0] c, input int d);
    int lo;
    lo = TB_MS * (d + RESP_MS);
    @(posedge clk);
    cur <= c;
    for (n = 0; (w ? zc : oc) !== 1'h1 && n < 2000; n++) @(negedge clk);
    chk("qualify_time", n >= lo && n <= lo + 20, 1'h1);
    @(posedge clk);
    cur <= 11'h1F4;
    for (n = 0; (w ? zc : oc) === 1'h1 && n < 2000; n++) @(negedge clk);
    chk("hold_time", n >= 390 && n <= 420, 1'h1);
endtask
task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// run-away guard
always @(posedge clk)
begin
    cyc++;
    if (cyc == 20000)
    begin
        num_errors++;
        tally_and_finish();
    end
end
////////////////////////////////////////////////////////////////////////////////
// main sequence
initial
begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    step(16'h0, 16'h258, 1'h0, 1'h0);
    step(16'h0, 16'h257, 1'h1, 1'h0);
    for (i = 0; i < 40; i++)
    begin
        bnd = i == 0 ? 16'h0 : 16'($unsigned($random(seed)) % 1001);
        fth = 16'($unsigned($random(seed)) % 40001);
        rth = i % 3 == 0 ? FREQ_SAME_AS_FWD : 16'($unsigned($random(seed)) % 40001);
        wr(2'h0, 3'h0, bnd, 1'h1);
        wr(2'h0, 3'h1, fth, 1'h1);
        wr(2'h0, 3'h2, rth, 1'h1);
        for (j = 0; j < 8; j++)
        begin
            n = $unsigned($random(seed)) % 40001;
            m = $unsigned($random(seed)) % (n * bnd / 1000 + 3);
            o = 16'((j[1] || m > n) ? n + m : n - m);
            step(16'(n), o, 1'($random(seed)), j == 5);
        end
    end
    $display("frequency test done");
    wr(2'h1, 3'h0, 16'h0, 1'h0);
    wr(2'h0, 3'h7, 16'h0, 1'h0);
    wr(2'h0, 3'h0, 16'h3E9, 1'h0);
    wr(2'h0, 3'h1, 16'h9C41, 1'h0);
    wr(2'h0, 3'h3, 16'h7D1, 1'h0);
    wr(2'h0, 3'h4, 16'h2711, 1'h0);
    wr(2'h0, 3'h6, 16'h3E9, 1'h0);
    $display("write test done");
    wr(2'h0, 3'h3, 16'h3E8, 1'h1);
    wr(2'h0, 3'h6, 16'h0, 1'h1);
    @(posedge clk);
    run <= 1'h1;
    cur <= 11'h5DC;
    repeat (200) @(posedge clk);
    cur <= 11'h1F4;
    repeat (12) @(posedge clk);
    qual(0, 11'h5DC, 0);
    qual(1, 11'h0, 0);
    wr(2'h0, 3'h5, 16'h0, 1'h1);
    @(posedge clk);
    cur <= 11'h0;
    repeat (600) @(negedge clk);
    chk("zc_disabled", zc, 1'h0);
    wr(2'h0, 3'h4, 16'h14, 1'h1);
    @(posedge clk);
    run <= 1'h0;
    tun <= 1'h1;
    qual(0, 11'h5DC, 20);
    @(posedge clk);
    tun <= 1'h0;
    cur <= 11'h5DC;
    repeat (600) @(negedge clk);
    chk("oc_stopped", oc, 1'h0);
    chk("oc_events", oc_seen, 8'h02);
    $display("current test done");
    tally_and_finish();
end
endmodule
